// file: pkg/pgr_pkg.sv
// Package: register map, configuration layout and mode codes for the pad register logic
package pgr_pkg;

   // ==========================================
   // Register map
   localparam int         WB_AW    = 8;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;

   // ==========================================
   // Pin modes
   localparam logic [1:0] MODE_IN    = 2'h0;
   localparam logic [1:0] MODE_OUT   = 2'h1;
   localparam logic [1:0] MODE_BIDIR = 2'h2;
   localparam logic [1:0] MODE_CLK   = 2'h3;

   // ==========================================
   // Bypass destinations
   localparam logic [1:0] BYP_CLOCK_NET = 2'h0;
   localparam logic [1:0] BYP_CTRL_NET  = 2'h1;
   localparam logic [1:0] BYP_SYNTH     = 2'h2;

   // ==========================================
   // Configuration word, first field is the most significant
   typedef struct packed {
      logic [1:0] byp_sel;
      logic       resync;
      logic       tx_dual;
      logic       rx_dual;
      logic       tx_inv;
      logic       oe_fall;
      logic       oe_reg;
      logic       tx_fall;
      logic       tx_reg;
      logic       rx_fall;
      logic       rx_reg;
      logic [1:0] mode;
   } pgr_cfg_t;

   localparam int          CFG_W    = $bits(pgr_cfg_t);
   localparam logic [13:0] CTRL_RST = 14'h0000;
   localparam int          STAT_W   = 6;

endpackage

// file: hw/pgr_pad_logic.sv
// Pad register logic: capture, launch and enable registers between fabric and one pad
`timescale 1ns/10ps
// Overview of operation
// - Input capture samples pad before fabric; output register holds fabric data before pad.
// - Output enable, direct or registered, switches the pad driver on and off.
// - Input mode uses only the input path, direct or registered on a chosen edge.
// - Bypass output feeds the alternate function without any capture stage.
// - Dual-edge input captures pad on both rx clock edges into two streams.
// - Output mode uses only the output path, direct or registered on a chosen edge.
// - Registered output value can be inverted toward the pad.
// - Dual-edge output launches two bits on both tx edges, muxed onto the pad.
// - Bidirectional uses all paths; rx clock for capture, tx clock for data and enable.
// - Every register has its own edge choice; input and output registered independently.
// - Clock-output mode drives the core clock tree level out through the pad.
// - Bypass works only with no input register; targets clock, control or synth reference.
// - Pins sharing differential-pair resources offer no dual-edge operation.
// - Dual-edge only on pins in banks that support it.
// - Dual-edge input: bit 0 rising sample, bit 1 falling sample.
// - Dual-edge output: bit 0 launched on rising, bit 1 on falling edge.
// - Resync mode delays the falling sample half a cycle to present on rising edge.
module pgr_pad_logic
   import pgr_pkg::*;
#(
   parameter int BANK_DUAL_EDGE = 1,
   parameter int LVDS_SHARED    = 0
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [WB_AW-1:0] wb_adr_i,
   input  wire logic [31:0]      wb_dat_i,
   input  wire logic [3:0]       wb_sel_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   // Fabric side
   input  wire logic             rx_reg_clk_i,
   input  wire logic             tx_reg_clk_i,
   input  wire logic             core_clk_tree_i,
   input  wire logic [1:0]       tx_data_i,
   input  wire logic             oe_i,
   output logic      [1:0]       rx_data_o,
   // Bypass destinations
   output logic                  global_clock_net_o,
   output logic                  global_ctrl_net_o,
   output logic                  synth_ref_input_o,
   // Pad
   input  wire logic             pad_i,
   output logic                  pad_o,
   output logic                  pad_oe_o
);

   // ==========================================
   // Elaboration checks
   if (!(BANK_DUAL_EDGE inside {0, 1}) || !(LVDS_SHARED inside {0, 1})) begin : g_bad_par
      $error("BANK_DUAL_EDGE and LVDS_SHARED must be 0 or 1");
   end
   // Shared differential resources never get dual-edge, even in a capable bank
   localparam logic DUAL_EDGE_OK = (BANK_DUAL_EDGE == 1) && (LVDS_SHARED == 0);

   pgr_cfg_t          ctrl_q;
   pgr_cfg_t          ctrl_d;
   logic              ack_q;
   logic              ack_d;
   logic [31:0]       dat_q;
   logic [31:0]       dat_d;
   logic [31:0]       wr_w;
   logic [STAT_W-1:0] stat_w;

   logic       rx_clk_q;
   logic       rx_cap0_q;
   logic       rx_cap0_d;
   logic       rx_cap1_q;
   logic       rx_cap1_d;
   logic       rx_rs_q;
   logic       rx_rs_d;
   logic [1:0] rx_data_q;
   logic [1:0] rx_data_d;
   logic [2:0] byp_q;
   logic [2:0] byp_d;
   logic       rx_rise;
   logic       rx_fall;
   logic       rx_edge;
   logic       rx_dual;
   logic       in_en;

   logic tx_clk_q;
   logic tx0_q;
   logic tx0_d;
   logic tx1_q;
   logic tx1_d;
   logic oe_q;
   logic oe_d;
   logic pad_q;
   logic pad_d;
   logic pad_oe_q;
   logic pad_oe_d;
   logic tx_rise;
   logic tx_fall;
   logic tx_edge;
   logic oe_edge;
   logic tx_dual;
   logic tx_val;
   logic drive;

   // ==========================================
   // Wishbone register file
   // Ack comes one cycle after the request and drops the cycle after
   assign stat_w = {pad_i, pad_oe_q, pad_q, rx_data_q, DUAL_EDGE_OK};

   always_comb begin
      ctrl_d = ctrl_q;
      wr_w   = {{(32 - CFG_W){1'b0}}, ctrl_q};
      ack_d  = wb_cyc_i & wb_stb_i & ~ack_q;
      dat_d  = 32'h0000_0000;
      if (ack_d) begin
         if (wb_adr_i == OFF_CTRL) begin
            dat_d = wr_w;
            if (wb_we_i) begin
               for (int b = 0; b < 4; b++) begin
                  if (wb_sel_i[b]) begin
                     wr_w[8*b +: 8] = wb_dat_i[8*b +: 8];
                  end
               end
               ctrl_d = pgr_cfg_t'(wr_w[CFG_W-1:0]);
            end
         end else if (wb_adr_i == OFF_STAT) begin
            dat_d = {{(32 - STAT_W){1'b0}}, stat_w};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= pgr_cfg_t'(CTRL_RST);
         ack_q  <= 1'b0;
         dat_q  <= 32'h0000_0000;
      end else begin
         ctrl_q <= ctrl_d;
         ack_q  <= ack_d;
         dat_q  <= dat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // ==========================================
   // Input path
   // The rx clock is sampled, so an edge is seen one cycle late; it must be slower than clk_i
   always_comb begin
      rx_rise   = rx_reg_clk_i & ~rx_clk_q;
      rx_fall   = ~rx_reg_clk_i & rx_clk_q;
      rx_edge   = ctrl_q.rx_fall ? rx_fall : rx_rise;
      in_en     = (ctrl_q.mode == MODE_IN) || (ctrl_q.mode == MODE_BIDIR);
      rx_dual   = ctrl_q.rx_dual & DUAL_EDGE_OK;
      rx_cap0_d = rx_cap0_q;
      rx_cap1_d = rx_cap1_q;
      rx_rs_d   = rx_rs_q;
      if (in_en && rx_dual) begin
         if (rx_rise) begin
            rx_cap0_d = pad_i;
            rx_rs_d   = rx_cap1_q;
         end
         if (rx_fall) begin
            rx_cap1_d = pad_i;
         end
      end else if (in_en && ctrl_q.rx_reg && rx_edge) begin
         rx_cap0_d = pad_i;
      end
      rx_data_d = 2'h0;
      if (in_en) begin
         if (rx_dual) begin
            rx_data_d = {ctrl_q.resync ? rx_rs_q : rx_cap1_q, rx_cap0_q};
         end else if (ctrl_q.rx_reg) begin
            rx_data_d = {1'b0, rx_cap0_q};
         end else begin
            rx_data_d = {1'b0, pad_i};
         end
      end
      byp_d = 3'h0;
      // Bypass only exists when nothing captures the pad
      if (ctrl_q.mode == MODE_IN && !ctrl_q.rx_reg && !rx_dual) begin
         byp_d[0] = (ctrl_q.byp_sel == BYP_CLOCK_NET) & pad_i;
         byp_d[1] = (ctrl_q.byp_sel == BYP_CTRL_NET) & pad_i;
         byp_d[2] = (ctrl_q.byp_sel == BYP_SYNTH) & pad_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_clk_q  <= rx_reg_clk_i;
         rx_cap0_q <= 1'b0;
         rx_cap1_q <= 1'b0;
         rx_rs_q   <= 1'b0;
         rx_data_q <= 2'h0;
         byp_q     <= 3'h0;
      end else begin
         rx_clk_q  <= rx_reg_clk_i;
         rx_cap0_q <= rx_cap0_d;
         rx_cap1_q <= rx_cap1_d;
         rx_rs_q   <= rx_rs_d;
         rx_data_q <= rx_data_d;
         byp_q     <= byp_d;
      end
   end

   assign rx_data_o          = rx_data_q;
   assign global_clock_net_o = byp_q[0];
   assign global_ctrl_net_o  = byp_q[1];
   assign synth_ref_input_o  = byp_q[2];

   // ==========================================
   // Output and enable path
   always_comb begin
      tx_rise = tx_reg_clk_i & ~tx_clk_q;
      tx_fall = ~tx_reg_clk_i & tx_clk_q;
      tx_edge = ctrl_q.tx_fall ? tx_fall : tx_rise;
      oe_edge = ctrl_q.oe_fall ? tx_fall : tx_rise;
      tx_dual = ctrl_q.tx_dual & DUAL_EDGE_OK;
      tx0_d   = tx0_q;
      tx1_d   = tx1_q;
      oe_d    = oe_q;
      if (tx_dual) begin
         if (tx_rise) begin
            tx0_d = tx_data_i[0];
         end
         if (tx_fall) begin
            tx1_d = tx_data_i[1];
         end
      end else if (ctrl_q.tx_reg && tx_edge) begin
         tx0_d = tx_data_i[0];
      end
      if (ctrl_q.oe_reg && oe_edge) begin
         oe_d = oe_i;
      end
      if (tx_dual) begin
         tx_val = tx_clk_q ? tx0_q : tx1_q;
      end else if (ctrl_q.tx_reg) begin
         tx_val = tx0_q;
      end else begin
         tx_val = tx_data_i[0];
      end
      if ((tx_dual || ctrl_q.tx_reg) && ctrl_q.tx_inv) begin
         tx_val = ~tx_val;
      end
      case (ctrl_q.mode)
         MODE_OUT: begin
            drive = 1'b1;
         end
         MODE_BIDIR: begin
            drive = ctrl_q.oe_reg ? oe_q : oe_i;
         end
         MODE_CLK: begin
            drive  = 1'b1;
            tx_val = core_clk_tree_i;
         end
         default: begin
            drive = 1'b0;
         end
      endcase
      pad_oe_d = drive;
      pad_d    = drive & tx_val;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_clk_q <= tx_reg_clk_i;
         tx0_q    <= 1'b0;
         tx1_q    <= 1'b0;
         oe_q     <= 1'b0;
         pad_q    <= 1'b0;
         pad_oe_q <= 1'b0;
      end else begin
         tx_clk_q <= tx_reg_clk_i;
         tx0_q    <= tx0_d;
         tx1_q    <= tx1_d;
         oe_q     <= oe_d;
         pad_q    <= pad_d;
         pad_oe_q <= pad_oe_d;
      end
   end

   assign pad_o    = pad_q;
   assign pad_oe_o = pad_oe_q;
   // ==========================================
   // Assertions
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_rx_comb_path: assert property (
      (in_en && !ctrl_q.rx_reg && !rx_dual) |=> rx_data_o[0] == $past(pad_i))
      else $error("direct input path wrong");
   a_rx_dual_rise: assert property (
      (rx_rise && rx_dual && in_en) ##1 ($stable(ctrl_q) && !rx_rise)
      |=> rx_data_o[0] == $past(pad_i, 2))
      else $error("rising sample not on bit 0");
   a_rx_dual_fall: assert property (
      (rx_fall && rx_dual && in_en && !ctrl_q.resync) ##1 ($stable(ctrl_q) && !rx_fall)
      |=> rx_data_o[1] == $past(pad_i, 2))
      else $error("falling sample not on bit 1");
   a_rx_resync_bit: assert property (
      (rx_rise && rx_dual && in_en && ctrl_q.resync) ##1 $stable(ctrl_q)
      |=> rx_data_o[1] == $past(rx_cap1_q, 2))
      else $error("resync sample wrong");
   a_bypass_clock: assert property (
      (ctrl_q.mode == MODE_IN && !ctrl_q.rx_reg && !rx_dual && ctrl_q.byp_sel == BYP_CLOCK_NET)
      |=> global_clock_net_o == $past(pad_i) && !global_ctrl_net_o)
      else $error("bypass clock path wrong");
   a_bypass_off: assert property (
      ctrl_q.rx_reg |=> !global_clock_net_o && !global_ctrl_net_o && !synth_ref_input_o)
      else $error("bypass active with input register");
   a_input_float: assert property (
      (ctrl_q.mode == MODE_IN) |=> !pad_oe_o && !pad_o)
      else $error("pad driven in input mode");
   a_bidir_oe: assert property (
      (ctrl_q.mode == MODE_BIDIR && !ctrl_q.oe_reg) |=> pad_oe_o == $past(oe_i))
      else $error("direct enable not followed");
   a_tx_invert: assert property (
      (ctrl_q.mode == MODE_OUT && ctrl_q.tx_reg && ctrl_q.tx_inv && !tx_dual)
      |=> pad_o == !$past(tx0_q))
      else $error("inverted output wrong");
   a_tx_dual_mux: assert property (
      (ctrl_q.mode == MODE_OUT && tx_dual && !ctrl_q.tx_inv)
      |=> pad_o == ($past(tx_clk_q) ? $past(tx0_q) : $past(tx1_q)))
      else $error("dual-edge output mux wrong");
   a_clk_out: assert property (
      (ctrl_q.mode == MODE_CLK) |=> pad_oe_o && pad_o == $past(core_clk_tree_i))
      else $error("clock output not driven");
   a_no_dual_edge: assert property (
      (in_en && !(ctrl_q.rx_dual && DUAL_EDGE_OK)) |=> rx_data_o[1] == 1'b0)
      else $error("dual-edge on incapable pin");
endmodule

// file: bench/pgr_pad_partner.sv
// Board-side model of the signal on the pad
`timescale 1ns/10ps
module pgr_pad_partner (
   // Clock
   input  wire logic clk_i,
   // Board drive request
   input  wire logic drv_en_i,
   input  wire logic drv_val_i,
   // Device pad driver
   input  wire logic pad_o_i,
   input  wire logic pad_oe_i,
   // Resolved pad level
   output logic      pad_lvl_o
);
   // ==========================================
   // Floating level
   // No pull on the line, so an undriven pad wanders instead of holding the last value
   logic flt_d;
   logic flt_q = 1'h0;
   always_comb flt_d = ~flt_q;
   always_ff @(posedge clk_i) flt_q <= flt_d;
   always_comb begin
      if (pad_oe_i) pad_lvl_o = pad_o_i;
      else if (drv_en_i) pad_lvl_o = drv_val_i;
      else pad_lvl_o = flt_q;
   end
endmodule

// file: bench/tb_top.sv
// Self-checking testbench for the pad register logic
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top;
   import pgr_pkg::*;
   // ==========================================
   // Rows: config, board drive, fabric inputs; then rx, pad, enable, bypass
   typedef struct packed {
      logic [13:0] cfg;
      logic        de, dv;
      logic [1:0]  tx;
      logic        oe, ck;
      logic [1:0]  rx;
      logic        po, poe, byp;
   } pgr_row_t;
   localparam int       NROW = 10;
   localparam pgr_row_t ROWS [NROW] = '{
      '{14'h0000, 1'h1, 1'h1, 2'h0, 1'h0, 1'h0, 2'h1, 1'h0, 1'h0, 1'h1},
      '{14'h0000, 1'h1, 1'h0, 2'h0, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0, 1'h0},
      '{14'h1000, 1'h1, 1'h1, 2'h0, 1'h0, 1'h0, 2'h1, 1'h0, 1'h0, 1'h1},
      '{14'h2000, 1'h1, 1'h1, 2'h0, 1'h0, 1'h0, 2'h1, 1'h0, 1'h0, 1'h1},
      '{14'h0001, 1'h0, 1'h0, 2'h1, 1'h0, 1'h0, 2'h0, 1'h1, 1'h1, 1'h0},
      '{14'h0001, 1'h0, 1'h0, 2'h2, 1'h0, 1'h0, 2'h0, 1'h0, 1'h1, 1'h0},
      '{14'h0002, 1'h1, 1'h1, 2'h1, 1'h0, 1'h0, 2'h1, 1'h0, 1'h0, 1'h0},
      '{14'h0002, 1'h0, 1'h0, 2'h1, 1'h1, 1'h0, 2'h1, 1'h1, 1'h1, 1'h0},
      '{14'h0003, 1'h0, 1'h0, 2'h0, 1'h0, 1'h1, 2'h0, 1'h1, 1'h1, 1'h0},
      '{14'h0003, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0, 2'h0, 1'h0, 1'h1, 1'h0}};
   // ==========================================
   // Stimulus and observed signals
   logic             clk_i = 1'h0, rst_i = 1'h1;
   logic             wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   logic [WB_AW-1:0] wb_adr_i = '0;
   logic [31:0]      wb_dat_i = '0, wb_dat_o, rd;
   logic [3:0]       wb_sel_i = 4'h0;
   logic             wb_ack_o, rx_clk = 1'h0, tx_clk = 1'h0, ck = 1'h0, oe = 1'h0;
   logic [1:0]       tx_data = 2'h0, rx_data_o;
   logic             drv_en = 1'h0, drv_val = 1'h0, pad_i, pad_o, pad_oe_o;
   logic [2:0]       byp;
   int               fail_count = 0, n_tests = 0;
   always #2.5 clk_i = ~clk_i;
   pgr_pad_logic pgr_pad_logic_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .rx_reg_clk_i(rx_clk), .tx_reg_clk_i(tx_clk), .core_clk_tree_i(ck),
      .tx_data_i(tx_data), .oe_i(oe), .rx_data_o(rx_data_o),
      .global_clock_net_o(byp[0]), .global_ctrl_net_o(byp[1]), .synth_ref_input_o(byp[2]),
      .pad_i(pad_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o));
   pgr_pad_partner pgr_pad_partner_inst (.clk_i(clk_i), .drv_en_i(drv_en),
      .drv_val_i(drv_val), .pad_o_i(pad_o), .pad_oe_i(pad_oe_o), .pad_lvl_o(pad_i));
   // ==========================================
   // Tasks
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wcy(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Classic cycle; request held until ack is sampled, bounded wait
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'h1 && k < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      if (wb_ack_o !== 1'h1) begin
         fail_count++;
         print_verdict();
      end
   endtask
   task automatic set_cfg(input logic [13:0] c);
      wb(1'h1, OFF_CTRL, {18'h0_0000, c});
   endtask
   // ==========================================
   // Main sequence
   initial begin
      wcy(5);
      rst_i <= 1'h0;
      wcy(1);
      `CHK("pad_oe_rst", 1'h0, pad_oe_o)
      wb(1'h0, OFF_CTRL, 32'h0000_0000);
      `CHK("ctrl_rst", 32'h0000_0000, rd)
      wb(1'h1, OFF_CTRL, 32'hFFFF_FFFF);
      wb(1'h0, OFF_CTRL, 32'h0000_0000);
      `CHK("ctrl_bits", 32'h0000_3FFF, rd)
      wb(1'h1, OFF_STAT, 32'h0000_0000);
      wb(1'h0, OFF_STAT, 32'h0000_0000);
      `CHK("stat_dual", 1'h1, rd[0])
      wb(1'h0, 8'h08, 32'h0000_0000);
      `CHK("unmapped", 32'h0000_0000, rd)
      for (int i = 0; i < NROW; i++) begin
         set_cfg(ROWS[i].cfg);
         drv_en <= ROWS[i].de;
         drv_val <= ROWS[i].dv;
         tx_data <= ROWS[i].tx;
         oe <= ROWS[i].oe;
         ck <= ROWS[i].ck;
         wcy(4);
         `CHK("row_rx", ROWS[i].rx, rx_data_o)
         `CHK("row_pad", ROWS[i].po, pad_o)
         `CHK("row_oe", ROWS[i].poe, pad_oe_o)
         if (ROWS[i].cfg[1:0] == MODE_IN) `CHK("row_byp", ROWS[i].byp, byp[ROWS[i].cfg[13:12]])
      end
      // Registered capture on either edge; pad changes between edges must not leak
      for (int f = 0; f < 2; f++) begin
         rx_clk <= f[0];
         set_cfg({10'h000, f[0], 3'h4});
         drv_en <= 1'h1;
         drv_val <= 1'h1;
         wcy(4);
         rx_clk <= ~f[0];
         wcy(4);
         `CHK("rx_reg", 1'h1, rx_data_o[0])
         drv_val <= 1'h0;
         wcy(4);
         `CHK("rx_hold", 1'h1, rx_data_o[0])
         rx_clk <= f[0];
         wcy(4);
         `CHK("rx_other_edge", 1'h1, rx_data_o[0])
         rx_clk <= ~f[0];
         wcy(4);
         `CHK("rx_next", 1'h0, rx_data_o[0])
      end
      // Dual-edge capture, plain and resync
      for (int r = 0; r < 2; r++) begin
         rx_clk <= 1'h0;
         set_cfg({2'h0, r[0], 2'h1, 9'h000});
         for (int e = 0; e < 4; e++) begin
            drv_val <= (e == 3);
            wcy(4);
            rx_clk <= ~rx_clk;
            wcy(4);
         end
         `CHK("rx_dual_fall", r ? 2'h0 : 2'h2, rx_data_o)
         rx_clk <= 1'h1;
         wcy(4);
         `CHK("rx_dual_rise", 2'h3, rx_data_o)
      end
      // Dual-edge launch
      tx_data <= 2'h2;
      set_cfg(14'h0401);
      rx_clk <= 1'h0;
      tx_clk <= 1'h1;
      wcy(4);
      `CHK("tx_dual_rise", 1'h0, pad_o)
      tx_clk <= 1'h0;
      wcy(4);
      `CHK("tx_dual_fall", 1'h1, pad_o)
      tx_data <= 2'h1;
      tx_clk <= 1'h1;
      wcy(4);
      `CHK("tx_dual_rise1", 1'h1, pad_o)
      tx_clk <= 1'h0;
      wcy(4);
      `CHK("tx_dual_fall0", 1'h0, pad_o)
      // Registered, inverted launch
      set_cfg(14'h0111);
      tx_clk <= 1'h1;
      wcy(4);
      `CHK("tx_inv", 1'h0, pad_o)
      tx_data <= 2'h0;
      wcy(4);
      `CHK("tx_hold", 1'h0, pad_o)
      tx_clk <= 1'h0;
      wcy(4);
      tx_clk <= 1'h1;
      wcy(4);
      `CHK("tx_inv_next", 1'h1, pad_o)
      // Bidirectional with registered enable
      drv_en <= 1'h0;
      oe <= 1'h1;
      tx_data <= 2'h1;
      set_cfg(14'h0052);
      tx_clk <= 1'h0;
      wcy(4);
      tx_clk <= 1'h1;
      wcy(4);
      `CHK("bidir_oe", 1'h1, pad_oe_o)
      `CHK("bidir_rx", 2'h1, rx_data_o)
      oe <= 1'h0;
      wcy(4);
      `CHK("oe_hold", 1'h1, pad_oe_o)
      tx_clk <= 1'h0;
      wcy(4);
      tx_clk <= 1'h1;
      wcy(4);
      `CHK("oe_off", 1'h0, pad_oe_o)
      // Falling-edge launch and enable; the rising edge must leave both alone
      tx_data <= 2'h0;
      oe <= 1'h1;
      set_cfg(14'h00F2);
      tx_clk <= 1'h0;
      wcy(4);
      `CHK("oe_fall_on", 1'h1, pad_oe_o)
      `CHK("tx_fall_load", 1'h0, pad_o)
      tx_data <= 2'h1;
      oe <= 1'h0;
      tx_clk <= 1'h1;
      wcy(4);
      `CHK("tx_fall_hold", 1'h0, pad_o)
      `CHK("oe_fall_hold", 1'h1, pad_oe_o)
      tx_clk <= 1'h0;
      wcy(4);
      `CHK("oe_fall_off", 1'h0, pad_oe_o)
      // Reset in mid-run while the pad is driven
      set_cfg(14'h0001);
      wcy(4);
      rst_i <= 1'h1;
      wcy(5);
      rst_i <= 1'h0;
      wcy(1);
      `CHK("pad_oe_mid_rst", 1'h0, pad_oe_o)
      `CHK("pad_mid_rst", 1'h0, pad_o)
      wb(1'h0, OFF_CTRL, 32'h0000_0000);
      `CHK("ctrl_mid_rst", 32'h0000_0000, rd)
      print_verdict();
   end
endmodule
